/* File: design/pcrc_pkg.sv */
// Package for the port crossbar routing control block.
// Assumes a single 100 MHz system clock and the core's byte-wide SFR port.
package pcrc_pkg;

  // Special-function addresses and the page that holds the crossbar registers.
  localparam logic [7:0] PCRC_ADDR_FIRST = 8'hE1;
  localparam logic [7:0] PCRC_ADDR_SECOND = 8'hE2;
  localparam logic [7:0] PCRC_ADDR_THIRD = 8'hC7;
  localparam logic [7:0] PCRC_PAGE_XBAR = 8'h0F;

  // Values after reset.
  localparam logic [7:0] PCRC_RST_FIRST = 8'h00;
  localparam logic [7:0] PCRC_RST_SECOND = 8'h00;
  localparam logic [7:0] PCRC_RST_THIRD = 8'h00;

  // Field positions in the second crossbar control register.
  localparam int PCRC_BIT_TIMER1 = 7;
  localparam int PCRC_BIT_TIMER0 = 6;
  localparam int PCRC_BIT_COUNTER_IN = 5;
  localparam int PCRC_FLD_IO_HI = 4;
  localparam int PCRC_FLD_IO_LO = 2;
  localparam int PCRC_BIT_CLOCK_OUT = 1;

  // Bits that hold state; bit 0 of the second register is not stored.
  localparam logic [7:0] PCRC_MASK_SECOND = 8'hFE;

  // Counter-array module lines and the reserved routing code.
  localparam int PCRC_IO_LINES = 6;
  localparam logic [2:0] PCRC_IO_RESERVED = 3'h7;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] third;
    logic [7:0] rdata;
    logic timer1_input_pin_enable;
    logic timer0_input_pin_enable;
    logic counter_input_pin_enable;
    logic [PCRC_IO_LINES-1:0] io_line_enable;
    logic clock_output_pin_enable;
  } pcrc_state_s;

endpackage

/* File: design/pcrc_io_decode.sv */
// Cumulative decoder for the counter-array module I/O routing field.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pcrc_io_decode
  import pcrc_pkg::*;
(
  // Routing code
  input wire logic [2:0] counter_array_io_count,
  // One enable per module line, line 0 first
  output logic [PCRC_IO_LINES-1:0] line_enable
);

  // Line n is routed once the code exceeds n; the reserved code routes nothing.
  genvar gi;
  generate
    for (gi = 0; gi < PCRC_IO_LINES; gi++) begin : g_line
      assign line_enable[gi] = (counter_array_io_count != PCRC_IO_RESERVED) &&
                               (counter_array_io_count > 3'(gi));
    end
  endgenerate

endmodule

/* File: design/pcrc_top.sv */
// Port crossbar routing control: holds the three crossbar control registers
// and turns the second one into per-signal pin routing enables.
// Assumes the core's SFR port is synchronous to clock, with one-cycle strobes.
//
// Summary of operation
// - Timer 1 input reaches pin only when bit 7 set.
// - Timer 0 input reaches pin only when bit 6 set.
// - Bit 5 routes counter external input.
// - Bits 4:2 add module lines cumulatively; 111 reserved.
// - Bit 1 routes inverted system clock out.
// - Second register at 0xE2 on page 0x0F.
// - First and third registers at 0xE1, 0xC7.
`timescale 1ns/1ps
module pcrc_top
  import pcrc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Raw register contents for the rest of the crossbar
  output logic [7:0] crossbar_control_first,
  output logic [7:0] crossbar_control_third,
  // Routing enables toward the pin assignment logic
  output logic timer1_input_pin_enable,
  output logic timer0_input_pin_enable,
  output logic counter_input_pin_enable,
  output logic [PCRC_IO_LINES-1:0] counter_array_line_enable,
  output logic clock_output_pin_enable
);

  // Value of every field at reset. Nothing is routed to a pin until software
  // writes the second register, so no pin carries a stray signal after reset.
  localparam pcrc_state_s PCRC_STATE_RESET = '{
    first: PCRC_RST_FIRST,
    second: PCRC_RST_SECOND,
    third: PCRC_RST_THIRD,
    rdata: 8'h00,
    timer1_input_pin_enable: 1'b0,
    timer0_input_pin_enable: 1'b0,
    counter_input_pin_enable: 1'b0,
    io_line_enable: '0,
    clock_output_pin_enable: 1'b0
  };

  // Registered state and the value it takes at the next edge.
  pcrc_state_s state_ff;
  pcrc_state_s nxt_state;

  // Access decode.
  logic on_page;
  logic hit_first;
  logic hit_second;
  logic hit_third;
  logic hit_any;
  logic wr_first;
  logic wr_second;
  logic wr_third;
  logic rd_first;
  logic rd_second;
  logic rd_third;
  logic rd_unmapped;

  // Second register: masked write value and the value about to be stored.
  logic [7:0] second_written;
  logic [7:0] nxt_second;

  // Routing fields of the value about to be stored.
  logic route_timer1;
  logic route_timer0;
  logic route_counter_in;
  logic [2:0] route_io_code;
  logic route_clock_out;
  logic [PCRC_IO_LINES-1:0] io_decoded;

  // The crossbar registers all sit on the crossbar page; any other page or
  // address leaves them untouched and reads as zero.
  assign on_page = (sfr_page == PCRC_PAGE_XBAR);
  assign hit_first = on_page && (sfr_addr == PCRC_ADDR_FIRST);
  assign hit_second = on_page && (sfr_addr == PCRC_ADDR_SECOND);
  assign hit_third = on_page && (sfr_addr == PCRC_ADDR_THIRD);
  assign hit_any = hit_first || hit_second || hit_third;

  // Strobes qualified by the address decode.
  assign wr_first = sfr_wr && hit_first;
  assign wr_second = sfr_wr && hit_second;
  assign wr_third = sfr_wr && hit_third;
  assign rd_first = sfr_rd && hit_first;
  assign rd_second = sfr_rd && hit_second;
  assign rd_third = sfr_rd && hit_third;
  assign rd_unmapped = sfr_rd && !hit_any;

  // Bit 0 is never stored, so a stray one written there cannot steer routing.
  assign second_written = sfr_wdata & PCRC_MASK_SECOND;

  // The enables are decoded from the value about to be stored, so each enable
  // changes on the same edge as the register. Taking that value from its own
  // net keeps the decoder out of a loop through nxt_state.
  assign nxt_second = wr_second ? second_written : state_ff.second;

  // Bit 7 routes the timer 1 input and bit 6 the timer 0 input.
  // Bit 5 routes the counter-array external counter input.
  // Bits 4:2 count the counter-array module lines routed, line 0 first.
  // Bit 1 routes the inverted system clock; bit 0 is not stored.
  assign route_timer1 = nxt_second[PCRC_BIT_TIMER1];
  assign route_timer0 = nxt_second[PCRC_BIT_TIMER0];
  assign route_counter_in = nxt_second[PCRC_BIT_COUNTER_IN];
  assign route_io_code = nxt_second[PCRC_FLD_IO_HI:PCRC_FLD_IO_LO];
  assign route_clock_out = nxt_second[PCRC_BIT_CLOCK_OUT];

  // Each code up to six adds one module line; the reserved code routes none.
  pcrc_io_decode u_io_decode (
    .counter_array_io_count(route_io_code),
    .line_enable(io_decoded)
  );

  always_comb begin
    nxt_state = state_ff;

    // Register writes; a read in the same cycle still sees the old value.
    if (wr_first) begin
      nxt_state.first = sfr_wdata;
    end
    nxt_state.second = nxt_second;
    if (wr_third) begin
      nxt_state.third = sfr_wdata;
    end

    // Read data is held until the next read, so the core may take it late.
    if (rd_first) begin
      nxt_state.rdata = state_ff.first;
    end
    if (rd_second) begin
      nxt_state.rdata = state_ff.second;
    end
    if (rd_third) begin
      nxt_state.rdata = state_ff.third;
    end
    if (rd_unmapped) begin
      nxt_state.rdata = 8'h00;
    end

    // Routing enables.
    nxt_state.timer1_input_pin_enable = route_timer1;
    nxt_state.timer0_input_pin_enable = route_timer0;
    nxt_state.counter_input_pin_enable = route_counter_in;
    nxt_state.io_line_enable = io_decoded;
    nxt_state.clock_output_pin_enable = route_clock_out;
  end

  // Synchronous reset; every output below comes straight from this register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= PCRC_STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Register bus.
  assign sfr_rdata = state_ff.rdata;

  // The first and third registers are only stored here; their fields steer
  // pin assignment further along the crossbar.
  assign crossbar_control_first = state_ff.first;
  assign crossbar_control_third = state_ff.third;

  // Routing enables.
  assign timer1_input_pin_enable = state_ff.timer1_input_pin_enable;
  assign timer0_input_pin_enable = state_ff.timer0_input_pin_enable;
  assign counter_input_pin_enable = state_ff.counter_input_pin_enable;
  assign counter_array_line_enable = state_ff.io_line_enable;
  assign clock_output_pin_enable = state_ff.clock_output_pin_enable;

endmodule

/* File: test/pcrc_checker.sv */
// Assertions on the port crossbar routing control ports.
// Bound to pcrc_top at the foot; reads its ports only.
`timescale 1ns/1ps
module pcrc_chk
  import pcrc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Stored registers
  input wire logic [7:0] crossbar_control_first,
  input wire logic [7:0] crossbar_control_third,
  // Routing enables
  input wire logic timer1_input_pin_enable,
  input wire logic timer0_input_pin_enable,
  input wire logic counter_input_pin_enable,
  input wire logic [PCRC_IO_LINES-1:0] counter_array_line_enable,
  input wire logic clock_output_pin_enable
);
  wire logic on_pg = sfr_page == PCRC_PAGE_XBAR;
  wire logic sel = sfr_wr && on_pg;
  wire logic w2 = sel && sfr_addr == PCRC_ADDR_SECOND;
  wire logic [9:0] en = {timer1_input_pin_enable, timer0_input_pin_enable,
    counter_input_pin_enable, counter_array_line_enable, clock_output_pin_enable};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_t1_route: assert property (w2 |=> en[9] == $past(sfr_wdata[7])) else $error("t1");
  a_t0_route: assert property (w2 |=> en[8] == $past(sfr_wdata[6])) else $error("t0");
  a_ci_route: assert property (w2 |=> en[7] == $past(sfr_wdata[5])) else $error("ci");
  a_ck_route: assert property (w2 |=> en[0] == $past(sfr_wdata[1])) else $error("ck");
  a_io_lines: assert property (w2 |=> en[6:1] == (&$past(sfr_wdata[4:2]) ? 6'h00 :
    6'h3F >> (3'h6 - $past(sfr_wdata[4:2])))) else $error("io");
  a_en_hold: assert property (!w2 |=> $stable(en)) else $error("hold");
  a_page_rd: assert property (sfr_rd && !on_pg |=> sfr_rdata == 8'h00)
    else $error("page");
  a_first_wr: assert property (sel && sfr_addr == PCRC_ADDR_FIRST |=>
    crossbar_control_first == $past(sfr_wdata)) else $error("first");
  a_third_wr: assert property (sel && sfr_addr == PCRC_ADDR_THIRD |=>
    crossbar_control_third == $past(sfr_wdata)) else $error("third");
  a_first_rd: assert property (sfr_rd && on_pg && sfr_addr == PCRC_ADDR_FIRST |=>
    sfr_rdata == $past(crossbar_control_first)) else $error("first read");
endmodule
bind pcrc_top pcrc_chk chk_u (.*);

/* File: test/test_pcrc_top.sv */
// Bench for pcrc_top: routing table, address decode and reset.
// Drives the register port at the falling edge; no other model.
`timescale 1ns/1ps
module test_pcrc_top;
  logic clock = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, clock_output_pin_enable;
  logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [7:0] crossbar_control_first, crossbar_control_third;
  logic timer1_input_pin_enable, timer0_input_pin_enable, counter_input_pin_enable;
  logic [5:0] counter_array_line_enable;
  wire logic [9:0] en = {timer1_input_pin_enable, timer0_input_pin_enable,
    counter_input_pin_enable, counter_array_line_enable, clock_output_pin_enable};
  int n_mismatch = 0, checked = 0;
  logic [17:0] rows [13] = '{{8'h80, 10'h200}, {8'h40, 10'h100}, {8'h20, 10'h080},
    {8'h02, 10'h001}, {8'h00, 10'h000}, {8'h04, 10'h002}, {8'h08, 10'h006}, {8'h0C, 10'h00E},
    {8'h10, 10'h01E}, {8'h14, 10'h03E}, {8'h18, 10'h07E}, {8'h1C, 10'h000}, {8'hFF, 10'h381}};
  always #5 clock = ~clock;
  pcrc_top dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_page(sfr_page),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .crossbar_control_first(crossbar_control_first),
    .crossbar_control_third(crossbar_control_third),
    .timer1_input_pin_enable(timer1_input_pin_enable),
    .timer0_input_pin_enable(timer0_input_pin_enable),
    .counter_input_pin_enable(counter_input_pin_enable),
    .counter_array_line_enable(counter_array_line_enable),
    .clock_output_pin_enable(clock_output_pin_enable)
  );
  task chk(input logic [33:0] g, e);
    checked++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask
  // An idle cycle follows each strobe so no strobe is set twice in one time step.
  task acc(input logic [25:0] v);
    {sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata} = v;
    @(negedge clock);
    {sfr_wr, sfr_rd} = 2'b00;
    @(negedge clock);
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000 n_mismatch++;
    test_done;
  end
  initial begin
    repeat (4) @(negedge clock);
    chk({en, crossbar_control_first, crossbar_control_third, sfr_rdata}, 34'h0);
    rst_n = 1;
    foreach (rows[i]) begin
      acc({2'b10, 8'h0F, 8'hE2, rows[i][17:10]});
      chk(en, rows[i][9:0]);
      acc({2'b01, 8'h0F, 8'hE2, 8'h00});
      chk(sfr_rdata, rows[i][17:10] & 8'hFE);
    end
    $display("Test table done");
    acc({2'b10, 8'h00, 8'hE2, 8'h00});
    acc({2'b10, 8'h0F, 8'hE3, 8'h00});
    acc({2'b01, 8'h00, 8'hE2, 8'h00});
    chk({en, sfr_rdata}, {10'h381, 8'h00});
    acc({2'b10, 8'h0F, 8'hE1, 8'hA5});
    acc({2'b10, 8'h0F, 8'hC7, 8'h5A});
    chk({crossbar_control_first, crossbar_control_third}, 16'hA55A);
    acc({2'b01, 8'h0F, 8'hE1, 8'h00});
    chk(sfr_rdata, 8'hA5);
    acc({2'b01, 8'h0F, 8'hC7, 8'h00});
    chk(sfr_rdata, 8'h5A);
    // Read and write together: the read returns the old byte.
    acc({2'b11, 8'h0F, 8'hE1, 8'h3C});
    chk({crossbar_control_first, sfr_rdata}, 16'h3CA5);
    $display("Test decode done");
    rst_n = 0;
    @(negedge clock);
    chk({en, crossbar_control_first, crossbar_control_third, sfr_rdata}, 34'h0);
    rst_n = 1;
    acc({2'b10, 8'h0F, 8'hE2, 8'h84});
    chk(en, 10'h202);
    $display("Test reset done");
    test_done;
  end
endmodule
